// File: rtl/spic_init_decode.sv
// Purpose: Write decode and init sequencing of the slave interrupt controller
// Assumes: One I/O access per strobe cycle, synchronous to SYS_CLK_IN
// Notes:   Prioritization and masking live outside this block
// Function
// - Cascade bit clear: slave bypassed, writes ignored
// - Even port decode: bit4 init one, bit3 op word
// - Op three read code 10/11 selects read source
// - Vector is base bits over request level
// - Init word one resets sequence and pointer
// - Odd port writes load init words two-four
// - Each odd write during init advances the init pointer; none in operate state
// - Single select fixed zero: word three expected
// - Fourth word skipped when not needed
// - Skipped fourth word takes value 01h
// - Read code 00/01 keeps previous read source
module spic_init_decode (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic [15:0] IO_ADDR_IN,
    input  wire logic        IO_WR_IN,
    input  wire logic        IO_RD_IN,
    input  wire logic [7:0]  IO_WDATA_IN,
    input  wire logic        SLAVE_CASCADE_PRESENT_IN,
    input  wire logic [7:0]  REQUEST_REG_IN,
    input  wire logic [7:0]  IN_SERVICE_REG_IN,
    input  wire logic [2:0]  REQUEST_LEVEL_IN,
    output logic      [7:0]  IO_RDATA_OUT,
    output logic      [7:0]  VECTOR_OUT,
    output logic             INIT_BUSY_OUT,
    output logic      [7:0]  INIT_WORD_ONE_OUT,
    output logic      [7:0]  INIT_WORD_THREE_OUT,
    output logic      [7:0]  INIT_WORD_FOUR_OUT,
    output logic      [7:0]  OP_WORD_TWO_OUT,
    output logic      [7:0]  OP_WORD_THREE_OUT,
    output logic             READ_SERVICE_SEL_OUT
);

    spic_pkg::spic_state_t state_q, state_d;
    logic [7:0]  word_one_q, word_one_d;
    logic [7:0]  vector_base_init_word_q, vector_base_init_word_d;
    logic [7:0]  word_three_q, word_three_d;
    logic [7:0]  word_four_q, word_four_d;
    logic [7:0]  op_two_q, op_two_d;
    logic [7:0]  op_three_q, op_three_d;
    logic        svc_sel_q, svc_sel_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [7:0]  vector_q, vector_d;
    logic        busy_q, busy_d;

    logic        wr_even, wr_odd, rd_even;
    logic        sel_one, sel_op3, sel_op2;

    assign wr_even = IO_WR_IN && SLAVE_CASCADE_PRESENT_IN && (IO_ADDR_IN == spic_pkg::EVEN_PORT_ADDR);
    assign wr_odd  = IO_WR_IN && SLAVE_CASCADE_PRESENT_IN && (IO_ADDR_IN == spic_pkg::ODD_PORT_ADDR);
    assign rd_even = IO_RD_IN && (IO_ADDR_IN == spic_pkg::EVEN_PORT_ADDR);
    assign sel_one = wr_even && IO_WDATA_IN[spic_pkg::SEL_INIT_ONE_BIT];
    assign sel_op2 = wr_even && !IO_WDATA_IN[spic_pkg::SEL_INIT_ONE_BIT]
                     && !IO_WDATA_IN[spic_pkg::SEL_OP_THREE_BIT];
    assign sel_op3 = wr_even && !IO_WDATA_IN[spic_pkg::SEL_INIT_ONE_BIT]
                     && IO_WDATA_IN[spic_pkg::SEL_OP_THREE_BIT]
                     && !IO_WDATA_IN[spic_pkg::OP_THREE_RSV_BIT];

    // Init sequence and register writes
    always_comb begin
        state_d                 = state_q;
        word_one_d              = word_one_q;
        vector_base_init_word_d = vector_base_init_word_q;
        word_three_d            = word_three_q;
        word_four_d             = word_four_q;
        op_two_d                = op_two_q;
        op_three_d              = op_three_q;
        svc_sel_d               = svc_sel_q;
        if (sel_one) begin
            word_one_d                            = IO_WDATA_IN;
            word_one_d[spic_pkg::SINGLE_SEL_BIT]  = 1'b0;
            state_d                               = spic_pkg::ST_WAIT_TWO;
        end else if (sel_op2) begin
            op_two_d = IO_WDATA_IN;
        end else if (sel_op3) begin
            op_three_d = IO_WDATA_IN;
            if (IO_WDATA_IN[1:0] == spic_pkg::READ_SEL_REQUEST) begin
                svc_sel_d = 1'b0;
            end else if (IO_WDATA_IN[1:0] == spic_pkg::READ_SEL_SERVICE) begin
                svc_sel_d = 1'b1;
            end
        end
        if (wr_odd) begin
            unique case (state_q)
                spic_pkg::ST_OPERATE: begin
                end
                spic_pkg::ST_WAIT_TWO: begin
                    vector_base_init_word_d = IO_WDATA_IN;
                    state_d                 = spic_pkg::ST_WAIT_THREE;
                end
                spic_pkg::ST_WAIT_THREE: begin
                    word_three_d = IO_WDATA_IN;
                    if (word_one_q[spic_pkg::FOURTH_NEEDED_BIT]) begin
                        state_d = spic_pkg::ST_WAIT_FOUR;
                    end else begin
                        word_four_d = spic_pkg::INIT_FOUR_DEFAULT;
                        state_d     = spic_pkg::ST_OPERATE;
                    end
                end
                spic_pkg::ST_WAIT_FOUR: begin
                    word_four_d = IO_WDATA_IN;
                    state_d     = spic_pkg::ST_OPERATE;
                end
            endcase
        end
        busy_d = (state_d != spic_pkg::ST_OPERATE);
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q                 <= spic_pkg::ST_OPERATE;
            busy_q                  <= 1'b0;
            word_one_q              <= spic_pkg::WORD_RESET;
            vector_base_init_word_q <= spic_pkg::WORD_RESET;
            word_three_q            <= spic_pkg::WORD_RESET;
            word_four_q             <= spic_pkg::INIT_FOUR_DEFAULT;
            op_two_q                <= spic_pkg::WORD_RESET;
            op_three_q              <= spic_pkg::WORD_RESET;
            svc_sel_q               <= 1'b0;
        end else begin
            state_q                 <= state_d;
            word_one_q              <= word_one_d;
            vector_base_init_word_q <= vector_base_init_word_d;
            word_three_q            <= word_three_d;
            word_four_q             <= word_four_d;
            op_two_q                <= op_two_d;
            op_three_q              <= op_three_d;
            svc_sel_q               <= svc_sel_d;
            busy_q                  <= busy_d;
        end
    end

    // Read data and vector formation
    always_comb begin
        rdata_d  = rdata_q;
        if (rd_even) begin
            rdata_d = svc_sel_q ? IN_SERVICE_REG_IN : REQUEST_REG_IN;
        end else if (IO_RD_IN) begin
            rdata_d = spic_pkg::READ_IDLE_DATA;
        end
        vector_d = {vector_base_init_word_q[spic_pkg::VEC_BASE_MSB:spic_pkg::VEC_BASE_LSB],
                    REQUEST_LEVEL_IN};
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rdata_q  <= spic_pkg::READ_IDLE_DATA;
            vector_q <= spic_pkg::WORD_RESET;
        end else begin
            rdata_q  <= rdata_d;
            vector_q <= vector_d;
        end
    end

    assign IO_RDATA_OUT         = rdata_q;
    assign VECTOR_OUT           = vector_q;
    assign INIT_BUSY_OUT        = busy_q;
    assign INIT_WORD_ONE_OUT    = word_one_q;
    assign INIT_WORD_THREE_OUT  = word_three_q;
    assign INIT_WORD_FOUR_OUT   = word_four_q;
    assign OP_WORD_TWO_OUT      = op_two_q;
    assign OP_WORD_THREE_OUT    = op_three_q;
    assign READ_SERVICE_SEL_OUT = svc_sel_q;

    // Checks
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_bypass_no_write: assert property (
        IO_WR_IN && !SLAVE_CASCADE_PRESENT_IN |=> $stable(state_q) && $stable(word_one_q)
            && $stable(op_two_q) && $stable(op_three_q) && $stable(vector_base_init_word_q))
        else $error("Write changed state while bypassed");

    a_init_one_load: assert property (
        sel_one |=> state_q == spic_pkg::ST_WAIT_TWO
            && word_one_q == {$past(IO_WDATA_IN[7:2]), 1'b0, $past(IO_WDATA_IN[0])})
        else $error("Init word one not loaded or sequence not reset");

    a_op_two_load: assert property (
        sel_op2 |=> op_two_q == $past(IO_WDATA_IN) && $stable(op_three_q))
        else $error("Op word two decode wrong");

    a_read_sel_set: assert property (
        sel_op3 && IO_WDATA_IN[1] |=> svc_sel_q == $past(IO_WDATA_IN[0]))
        else $error("Read source not selected");

    a_read_sel_keep: assert property (
        sel_op3 && !IO_WDATA_IN[1] |=> $stable(svc_sel_q))
        else $error("Read source changed on no-change code");

    a_vector_form: assert property (
        ##1 VECTOR_OUT == {$past(vector_base_init_word_q[7:3]), $past(REQUEST_LEVEL_IN)})
        else $error("Vector not base over level");

    a_odd_sequence: assert property (
        wr_odd && state_q == spic_pkg::ST_WAIT_TWO |=> state_q == spic_pkg::ST_WAIT_THREE
            && vector_base_init_word_q == $past(IO_WDATA_IN))
        else $error("Init word two not taken or pointer stuck");

    a_skip_four: assert property (
        wr_odd && !sel_one && state_q == spic_pkg::ST_WAIT_THREE && !word_one_q[0]
            |=> state_q == spic_pkg::ST_OPERATE && word_four_q == 8'h01)
        else $error("Fourth word not skipped with default");

    a_need_four: assert property (
        wr_odd && state_q == spic_pkg::ST_WAIT_THREE && word_one_q[spic_pkg::FOURTH_NEEDED_BIT]
            |=> state_q == spic_pkg::ST_WAIT_FOUR && word_three_q == $past(IO_WDATA_IN))
        else $error("Fourth word not expected");

    a_four_load: assert property (
        wr_odd && state_q == spic_pkg::ST_WAIT_FOUR
            |=> state_q == spic_pkg::ST_OPERATE && word_four_q == $past(IO_WDATA_IN))
        else $error("Init word four not loaded");

    a_even_read: assert property (
        rd_even |=> IO_RDATA_OUT == ($past(svc_sel_q) ? $past(IN_SERVICE_REG_IN) : $past(REQUEST_REG_IN)))
        else $error("Even port read source wrong");

endmodule : spic_init_decode

// File: rtl/spic_pkg.sv
// Purpose: Constants for the slave interrupt controller port decode
// Assumes: Byte-wide I/O ports on a 16-bit I/O address
// Notes:   Shared by design and bench
package spic_pkg;
    localparam logic [15:0] EVEN_PORT_ADDR     = 16'h00A0;
    localparam logic [15:0] ODD_PORT_ADDR      = 16'h00A1;
    localparam int          SEL_INIT_ONE_BIT   = 4;
    localparam int          SEL_OP_THREE_BIT   = 3;
    localparam int          OP_THREE_RSV_BIT   = 7;
    localparam int          FOURTH_NEEDED_BIT  = 0;
    localparam int          SINGLE_SEL_BIT     = 1;
    localparam int          VEC_BASE_MSB       = 7;
    localparam int          VEC_BASE_LSB       = 3;
    localparam int          LEVEL_W            = 3;
    localparam logic [1:0]  READ_SEL_REQUEST   = 2'h2;
    localparam logic [1:0]  READ_SEL_SERVICE   = 2'h3;
    localparam logic [7:0]  INIT_FOUR_DEFAULT  = 8'h01;
    localparam logic [7:0]  WORD_RESET         = 8'h00;
    localparam logic [7:0]  READ_IDLE_DATA     = 8'h00;

    typedef enum logic [1:0] {
        ST_OPERATE,
        ST_WAIT_TWO,
        ST_WAIT_THREE,
        ST_WAIT_FOUR
    } spic_state_t;
endpackage : spic_pkg

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the slave interrupt controller port decode
// Assumes: One access per strobe cycle; outputs settle one edge after the access, VECTOR_OUT two edges after it
// Notes:   Driver queues expectations, monitor compares them one edge later
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int grp; int which; logic [7:0] val;} spic_note_t;
    localparam logic [15:0] EV = spic_pkg::EVEN_PORT_ADDR;
    localparam logic [15:0] OD = spic_pkg::ODD_PORT_ADDR;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, casc = 1'b1, busy, sel, acc_q = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, req = 8'h00, isr = 8'h00, rdata, vec, w1, w3, w4, op2, op3;
    logic [2:0]  lvl = 3'h0;
    logic [31:0] lf = 32'hF15C5770;
    int          n_errors = 0, checks = 0, grp = 0, seen = 0, cyc = 0;
    spic_note_t  notes[$];

    spic_init_decode dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .IO_ADDR_IN(addr), .IO_WR_IN(wr),
        .IO_RD_IN(rd), .IO_WDATA_IN(wdata), .SLAVE_CASCADE_PRESENT_IN(casc), .REQUEST_REG_IN(req),
        .IN_SERVICE_REG_IN(isr), .REQUEST_LEVEL_IN(lvl), .IO_RDATA_OUT(rdata), .VECTOR_OUT(vec),
        .INIT_BUSY_OUT(busy), .INIT_WORD_ONE_OUT(w1), .INIT_WORD_THREE_OUT(w3),
        .INIT_WORD_FOUR_OUT(w4), .OP_WORD_TWO_OUT(op2), .OP_WORD_THREE_OUT(op3),
        .READ_SERVICE_SEL_OUT(sel));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [7:0] pick(input int w);
        case (w)
            0: return rdata;
            1: return vec;
            2: return {7'h00, busy};
            3: return w1;
            4: return w3;
            5: return w4;
            6: return op2;
            7: return op3;
            default: return {7'h00, sel};
        endcase
    endfunction : pick

    function automatic logic [7:0] vb(input logic [7:0] d);
        return {d[7:3], lvl};
    endfunction : vb

    task automatic wrap_up();
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: output %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= d;
        grp++;
    endtask : acc

    task automatic ex(input int which, input logic [7:0] val);
        notes.push_back('{grp - 1, which, val});
    endtask : ex

    task automatic idle();
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : idle

    task automatic rnd();
        @(posedge clk);
        lf = lfsr(lf);
        req <= lf[7:0];
        isr <= lf[15:8];
        lvl <= lf[18:16];
        @(posedge clk);
    endtask : rnd

    always @(posedge clk) begin
        if (acc_q) begin
            while (notes.size() > 0 && notes[0].grp == seen) begin
                chk(pick(notes[0].which), notes[0].val);
                void'(notes.pop_front());
            end
            seen++;
        end
        acc_q = wr | rd;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(w4, spic_pkg::INIT_FOUR_DEFAULT);
        chk({7'h00, busy}, 8'h00);
        rnd();
        acc(1, 0, EV, 8'h11); ex(2, 8'h01); ex(3, 8'h11);
        acc(1, 0, OD, 8'h70); ex(2, 8'h01);
        acc(1, 0, OD, 8'h00); ex(4, 8'h00); ex(2, 8'h01); ex(1, vb(8'h70));
        acc(1, 0, OD, 8'h02); ex(5, 8'h02); ex(2, 8'h00);
        acc(1, 0, EV, 8'h13); ex(3, 8'h11); ex(2, 8'h01);
        acc(1, 0, OD, 8'h70);
        acc(1, 0, EV, 8'h10); ex(3, 8'h10); ex(2, 8'h01);
        acc(1, 0, OD, 8'hA8); ex(2, 8'h01);
        acc(1, 0, OD, 8'h05); ex(4, 8'h05); ex(5, 8'h01); ex(2, 8'h00);
        ex(1, vb(8'hA8));
        acc(1, 0, OD, 8'h33); ex(4, 8'h05); ex(5, 8'h01);
        idle();
        rnd();
        acc(1, 0, EV, 8'h05); ex(6, 8'h05);
        acc(1, 0, EV, 8'h0B); ex(7, 8'h0B); ex(8, 8'h01);
        acc(0, 1, EV, 8'h00); ex(0, isr);
        acc(1, 0, EV, 8'h08); ex(8, 8'h01);
        acc(1, 0, EV, 8'h09); ex(8, 8'h01);
        acc(0, 1, EV, 8'h00); ex(0, isr);
        acc(1, 0, EV, 8'h0A); ex(8, 8'h00);
        acc(0, 1, EV, 8'h00); ex(0, req);
        acc(1, 0, EV, 8'h8B); ex(7, 8'h0A); ex(8, 8'h00);
        acc(0, 1, OD, 8'h00); ex(0, 8'h00);
        acc(0, 1, 16'h0042, 8'h00); ex(0, 8'h00);
        idle();
        casc <= 1'b0;
        acc(1, 0, EV, 8'h11); ex(2, 8'h00); ex(3, 8'h10);
        acc(1, 0, OD, 8'hF8); ex(1, vb(8'hA8)); ex(4, 8'h05);
        acc(0, 1, EV, 8'h00); ex(0, req);
        idle();
        repeat (3) @(posedge clk);
        wrap_up();
    end
endmodule : tb_top
